// file: pdn_sync_ref_regs.vh
// Register map, field positions and reset values for power-down mask and sync/reference control
//
// Function
// - Clock buffer mask bit keeps buffer powered
// - Reference amp mask bit keeps amp powered
// - Bandgap bit set lets bandgap power down when power down is active
// - Shared pin: power down or sync
// - Register sync bit toggle issues sync
// - Sync bit never self-clears; host rewrites
// - Bit 5 selects register sync source
// - Bit 3 gives reference to register
// - Reference code used only under register control
// - Bit 0 selects single-ended clock input, only under register control
// - Global power down request, mask decides blocks
`ifndef PDN_SYNC_REF_REGS_VH
`define PDN_SYNC_REF_REGS_VH

// ----------------------------------------
// Register addresses and reset values
// ----------------------------------------
`define ADDR_MASK 8'h0d
`define ADDR_SYNCREF 8'h0e
`define RESET_MASK 8'h00
`define RESET_SYNCREF 8'h00

// ----------------------------------------
// Mask register fields
// ----------------------------------------
`define MASK_KEEP_CLKBUF 3
`define MASK_KEEP_REFAMP 2
`define MASK_BG_OFF 1
`define MASK_WRITABLE 8'h0e

// ----------------------------------------
// Sync/reference register fields
// ----------------------------------------
`define SR_PIN_IS_SYNC 7
`define SR_REG_SYNC 6
`define SR_REG_SYNC_EN 5
`define SR_REF_REG_CTL 3
`define SR_REF_SEL_HI 2
`define SR_REF_SEL_LO 1
`define SR_SE_CLK 0
`define SR_WRITABLE 8'hef

// Reference selector codes
`define REF_INTERNAL 2'h0
`define REF_EXT_BUFFERED 2'h1
`define REF_EXTERNAL 2'h2

`endif

// file: sync_two_ff.v
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module sync_two_ff (
   // Clock and reset
   input wire mclk,
   input wire rst,
   input wire clkEn,
   // Level in and out
   input wire asyncIn,
   output wire syncOut
);
   reg stage1_reg;
   reg stage2_reg;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end else if (clkEn) begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;
endmodule

// file: ref_clock_select.v
// Reference source and clock input style selection
`timescale 1ns/10ps
`include "pdn_sync_ref_regs.vh"
module ref_clock_select (
   // Clock and reset
   input wire mclk,
   input wire rst,
   input wire clkEn,
   // Controls
   input wire regControl,
   input wire [1:0] regRefSel,
   input wire regSeClock,
   input wire [1:0] pinRefSel,
   // Results
   output reg [1:0] refSelect,
   output reg singleEndedClock,
   output reg diffClockBufOn
);
   reg [1:0] refNext;

   always @* begin
      refNext = pinRefSel;
      if (regControl) begin
         refNext = regRefSel;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         refSelect <= `REF_INTERNAL;
         singleEndedClock <= 1'b0;
         diffClockBufOn <= 1'b1;
      end else if (clkEn) begin
         refSelect <= refNext;
         singleEndedClock <= regControl & regSeClock;
         diffClockBufOn <= ~(regControl & regSeClock);
      end
   end
endmodule

// file: pdn_mask_sync_ref_ctrl.v
// Power-down mask and sync/reference control register bank
`timescale 1ns/10ps
`include "pdn_sync_ref_regs.vh"
module pdn_mask_sync_ref_ctrl (
   // Clock and reset
   input wire mclk,
   input wire rst,
   input wire clkEn,
   // Register access from the serial port decoder
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata,
   // Power-down control register bit
   input wire global_power_down_request,
   // Pins
   input wire shared_sync_powerdown_pin,
   input wire [1:0] reference_buffer_pin,
   // Power-down outputs, high means the block is powered; globalPowerDown high means power down is active
   output reg clockBufPowered,
   output reg referenceAmpPowered,
   output reg bandgapPowered,
   output reg globalPowerDown,
   // Sync
   output reg syncPulse,
   // Reference and clock style
   output wire [1:0] refSelect,
   output wire singleEndedClock,
   output wire diffClockBufOn
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] global_power_down_mask_reg;
   reg [7:0] sync_reference_control_reg;
   reg regSyncPrev_reg;
   reg pinPrev_reg;
   wire pinSync;
   wire [1:0] pinRefSync;
   wire pdnActive;
   wire pinIsSync;
   wire regSyncEn;
   wire regSyncToggle;
   wire pinRise;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // A block stays on unless power down is active and not masked
   function keep_powered(input down, input keep);
      begin
         keep_powered = ~down | keep;
      end
   endfunction

   // Reserved bits are masked so they read back zero whatever the host wrote
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         global_power_down_mask_reg <= `RESET_MASK;
         sync_reference_control_reg <= `RESET_SYNCREF;
      end else if (clkEn && regWrite) begin
         if (regAddr == `ADDR_MASK) begin
            global_power_down_mask_reg <= regWdata & `MASK_WRITABLE;
         end
         if (regAddr == `ADDR_SYNCREF) begin
            // Sync bit is kept as written, never cleared here
            sync_reference_control_reg <= regWdata & `SR_WRITABLE;
         end
      end
   end

   always @* begin
      case (regAddr)
         `ADDR_MASK: regRdata = global_power_down_mask_reg;
         `ADDR_SYNCREF: regRdata = sync_reference_control_reg;
         default: regRdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   sync_two_ff pinSyncInst (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .asyncIn(shared_sync_powerdown_pin),
      .syncOut(pinSync)
   );

   sync_two_ff refSync0 (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .asyncIn(reference_buffer_pin[0]),
      .syncOut(pinRefSync[0])
   );

   sync_two_ff refSync1 (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .asyncIn(reference_buffer_pin[1]),
      .syncOut(pinRefSync[1])
   );

   // ----------------------------------------
   // Power down and sync
   // ----------------------------------------
   assign pinIsSync = sync_reference_control_reg[`SR_PIN_IS_SYNC];
   assign regSyncEn = sync_reference_control_reg[`SR_REG_SYNC_EN];
   assign pdnActive = global_power_down_request | (~pinIsSync & pinSync);
   // A 0-to-1 write of the sync bit is the command edge
   assign regSyncToggle = sync_reference_control_reg[`SR_REG_SYNC] & ~regSyncPrev_reg;
   assign pinRise = pinSync & ~pinPrev_reg;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         regSyncPrev_reg <= 1'b0;
         pinPrev_reg <= 1'b0;
         syncPulse <= 1'b0;
         globalPowerDown <= 1'b0;
         clockBufPowered <= 1'b1;
         referenceAmpPowered <= 1'b1;
         bandgapPowered <= 1'b1;
      end else if (clkEn) begin
         regSyncPrev_reg <= sync_reference_control_reg[`SR_REG_SYNC];
         pinPrev_reg <= pinSync;
         // Register source replaces the pin when enabled
         if (regSyncEn) begin
            syncPulse <= regSyncToggle;
         end else begin
            syncPulse <= pinIsSync & pinRise;
         end
         globalPowerDown <= pdnActive;
         clockBufPowered <= keep_powered(pdnActive,
            global_power_down_mask_reg[`MASK_KEEP_CLKBUF]);
         referenceAmpPowered <= keep_powered(pdnActive,
            global_power_down_mask_reg[`MASK_KEEP_REFAMP]);
         // Inverted sense: set means bandgap goes down when power down is active, slower wake-up
         bandgapPowered <= keep_powered(pdnActive,
            ~global_power_down_mask_reg[`MASK_BG_OFF]);
      end
   end

   // ----------------------------------------
   // Reference and clock selection
   // ----------------------------------------
   ref_clock_select refClkInst (
      .mclk(mclk),
      .rst(rst),
      .clkEn(clkEn),
      .regControl(sync_reference_control_reg[`SR_REF_REG_CTL]),
      .regRefSel(sync_reference_control_reg[`SR_REF_SEL_HI:`SR_REF_SEL_LO]),
      .regSeClock(sync_reference_control_reg[`SR_SE_CLK]),
      .pinRefSel(pinRefSync),
      .refSelect(refSelect),
      .singleEndedClock(singleEndedClock),
      .diffClockBufOn(diffClockBufOn)
   );
endmodule

// file: pdn_mask_sync_ref_ctrl_checker.sv
// Port-level assertions for the power-down mask and sync/reference bank
`timescale 1ns/10ps
module pdn_mask_sync_ref_ctrl_checker (
   // Clock and reset
   input wire mclk,
   input wire rst,
   input wire clkEn,
   // Register access and request
   input wire regWrite,
   input wire [7:0] regAddr,
   input wire [7:0] regWdata,
   input wire [7:0] regRdata,
   input wire global_power_down_request,
   // Outputs
   input wire clockBufPowered,
   input wire referenceAmpPowered,
   input wire bandgapPowered,
   input wire globalPowerDown,
   input wire syncPulse,
   input wire [1:0] refSelect,
   input wire singleEndedClock,
   input wire diffClockBufOn
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_gpd; clkEn && global_power_down_request |=> globalPowerDown; endproperty
   a_gpd: assert property (p_gpd) else $error("power down late");
   property p_mask; $rose(globalPowerDown) && regAddr == 8'h0d && $stable(regAddr)
      && $stable(regRdata) |-> clockBufPowered == regRdata[3]
      && referenceAmpPowered == regRdata[2] && bandgapPowered != regRdata[1]; endproperty
   a_mask: assert property (p_mask) else $error("mask ignored");
   property p_se; singleEndedClock != diffClockBufOn; endproperty
   a_se: assert property (p_se) else $error("clock buffers clash");
   property p_one; syncPulse |=> !syncPulse; endproperty
   a_one: assert property (p_one) else $error("sync repeats");
   property p_wr; clkEn && regWrite && regAddr == 8'h0e ##1 regAddr == 8'h0e
      |-> regRdata == ($past(regWdata) & 8'hef); endproperty
   a_wr: assert property (p_wr) else $error("write lost");
   property p_sync; clkEn && regWrite && regAddr == 8'h0e && regWdata[6:5] == 2'h3
      && regRdata[6:5] == 2'h1 |-> ##2 syncPulse; endproperty
   a_sync: assert property (p_sync) else $error("no sync");
   property p_nosync; clkEn && regWrite && regAddr == 8'h0e && regWdata[7:5] == 3'h2
      && !regRdata[7] |-> ##2 !syncPulse; endproperty
   a_nosync: assert property (p_nosync) else $error("sync while disabled");
   property p_ref; $past(clkEn) && regAddr == 8'h0e && regRdata[3] && $stable(regAddr)
      && $stable(regRdata) |-> refSelect == regRdata[2:1]
      && singleEndedClock == regRdata[0]; endproperty
   a_ref: assert property (p_ref) else $error("reference not applied");
endmodule
bind pdn_mask_sync_ref_ctrl pdn_mask_sync_ref_ctrl_checker chk_u (
   .mclk(mclk),
   .rst(rst),
   .clkEn(clkEn),
   .regWrite(regWrite),
   .regAddr(regAddr),
   .regWdata(regWdata),
   .regRdata(regRdata),
   .global_power_down_request(global_power_down_request),
   .clockBufPowered(clockBufPowered),
   .referenceAmpPowered(referenceAmpPowered),
   .bandgapPowered(bandgapPowered),
   .globalPowerDown(globalPowerDown),
   .syncPulse(syncPulse),
   .refSelect(refSelect),
   .singleEndedClock(singleEndedClock),
   .diffClockBufOn(diffClockBufOn)
);

// file: test_pdn_mask_sync_ref_ctrl.sv
// Self-checking bench for the power-down mask and sync/reference bank
`timescale 1ns/10ps
module test_pdn_mask_sync_ref_ctrl;
   reg mclk = 0, rst = 1, regWrite = 0, req = 0, pin = 0, look = 0, clkEn = 1;
   reg [7:0] regAddr = 8'h00, regWdata = 8'h00, m0 = 8'h00, m1 = 8'h00, a, d;
   reg [1:0] refPin = 2'h0;
   reg [31:0] r;
   reg [63:0] sv = {8'h20, 8'h60, 8'h60, 8'h20, 8'h60, 8'h00, 8'h40, 8'h00};
   wire [7:0] regRdata;
   wire cb, ra, bg, gpd, syncPulse, se, diff;
   wire [1:0] refSel;
   reg [15:0] noteQ[$];
   reg sq[$];
   integer n_mismatch = 0, checks = 0, i;
   always #50 mclk = ~mclk;
   pdn_mask_sync_ref_ctrl dut_u (.mclk(mclk), .rst(rst), .clkEn(clkEn), .regWrite(regWrite),
      .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
      .global_power_down_request(req), .shared_sync_powerdown_pin(pin),
      .reference_buffer_pin(refPin), .clockBufPowered(cb), .referenceAmpPowered(ra),
      .bandgapPowered(bg), .globalPowerDown(gpd), .syncPulse(syncPulse),
      .refSelect(refSel), .singleEndedClock(se), .diffClockBufOn(diff));
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task cmp_sync(input got, input exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t sync note %b want %b", $time, got, exp);
         end
      end
   endtask
   // Expected port picture from the register model and current inputs
   function [15:0] snap(input [7:0] ad);
      reg pd;
      begin
         pd = req | (!m1[7] & pin);
         snap = {ad == 8'h0d ? m0 : ad == 8'h0e ? m1 : 8'h00, !pd | m0[3], !pd | m0[2],
            !pd | !m0[1], pd, m1[3] ? m1[2:1] : refPin, m1[3] & m1[0], !(m1[3] & m1[0])};
      end
   endfunction
   task wr(input [7:0] ad, input [7:0] dt);
      begin
         regAddr = ad;
         regWdata = dt;
         regWrite = 1;
         if (ad == 8'h0d) m0 = dt & 8'h0e;
         if (ad == 8'h0e) begin
            if (dt[6] & !m1[6] & dt[5]) sq.push_back(1'b1);
            m1 = dt & 8'hef;
         end
         @(posedge mclk);
         #1;
      end
   endtask
   task peek(input [7:0] ad);
      begin
         regAddr = ad;
         look = 1;
         noteQ.push_back(snap(ad));
         @(posedge mclk);
         #1 look = 0;
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge mclk) begin
      if (look) cmp({regRdata, cb, ra, bg, gpd, refSel, se, diff}, noteQ.pop_front());
      if (syncPulse) cmp_sync(syncPulse, sq.size() != 0);
      if (syncPulse && sq.size() != 0) sq.pop_front();
   end
   initial begin
      r = $urandom(32'h5cfbad17);
      repeat (4) @(posedge mclk);
      #1 rst = 0;
      peek(8'h0d);
      // Back-to-back rewrites; a held sync bit must not resync
      for (i = 0; i < 8; i = i + 1) wr(8'h0e, sv[63 - 8 * i -: 8]);
      regWrite = 0;
      repeat (4) @(posedge mclk);
      #1;
      peek(8'h0e);
      cmp_sync(sq.size() != 0, 1'b0);
      $display("test sync done");
      for (i = 0; i < 80; i = i + 1) begin
         pin = 0;
         req = 0;
         repeat (4) @(posedge mclk);
         #1 r = $urandom;
         a = 8'h0c + {6'h0, r[17:16]};
         d = r[15:8];
         if (d[2:1] == 2'h3) d[2] = 1'b0;
         if (d[5] != m1[5]) d[6] = m1[6];
         wr(a, d & (a == 8'h0d ? 8'h0e : 8'hef));
         regWrite = 0;
         r = $urandom;
         req = r[0];
         pin = r[1];
         refPin = (r[3:2] == 2'h3) ? 2'h1 : r[3:2];
         if (pin & m1[7] & !m1[5]) sq.push_back(1'b1);
         repeat (4) @(posedge mclk);
         #1;
         peek(8'h0c + {6'h0, r[5:4]});
      end
      $display("test random done");
      pin = 0;
      req = 0;
      refPin = 2'h0;
      repeat (6) @(posedge mclk);
      cmp_sync(sq.size() != 0, 1'b0);
      // Frozen clock enable must swallow a write
      #1 regAddr = 8'h0d;
      regWdata = ~m0 & 8'h0e;
      regWrite = 1;
      clkEn = 0;
      @(posedge mclk);
      #1 regWrite = 0;
      clkEn = 1;
      peek(8'h0d);
      $display("test freeze done");
      // Reset in mid-run returns every output to its idle picture
      @(posedge mclk);
      #1 rst = 1;
      m0 = 8'h00;
      m1 = 8'h00;
      repeat (2) @(posedge mclk);
      #1 rst = 0;
      peek(8'h0e);
      @(posedge mclk);
      #1;
      peek(8'h0d);
      $display("test reset done");
      print_verdict;
   end
endmodule
